// *** core/urxe_params.svh ***
// Purpose: constants for the receiver status, error and wakeup block
// Assumes: 10 MHz module clock, oversample tick supplied at 16x baud
// Notes:   all counts and sample positions as macros
`ifndef URXE_PARAMS_SVH
`define URXE_PARAMS_SVH
`define URXE_TICKS_PER_BIT   5'd16
`define URXE_START_S1        4'd3
`define URXE_START_S2        4'd5
`define URXE_START_S3        4'd7
`define URXE_BIT_S1          4'd8
`define URXE_BIT_S2          4'd9
`define URXE_BIT_S3          4'd10
`define URXE_LAST_TICK       4'd15
`define URXE_BITS_8          4'd9
`define URXE_BITS_9          4'd10
`define URXE_IDLE_8          4'd10
`define URXE_IDLE_9          4'd11
`define URXE_DATA_RESET      9'h000
`endif

// *** core/urxe_pkg.sv ***
// Purpose: types for the receiver status, error and wakeup block
// Assumes: included params header holds the numbers
// Notes:   flags and enables travel as packed structs
package urxe_pkg;
    // receiver state
    typedef enum logic [1:0] {
        URXE_IDLE,
        URXE_START,
        URXE_DATA,
        URXE_STOP
    } urxe_state_t;
    // status flags seen by software
    typedef struct packed {
        logic rx_full;
        logic quiet;
        logic overrun;
        logic noise;
        logic frame;
        logic par_fault;
    } urxe_flags_t;
    // interrupt enables
    typedef struct packed {
        logic rx_full;
        logic quiet;
        logic overrun;
        logic noise;
        logic frame;
        logic par_fault;
    } urxe_irq_en_t;
endpackage

// *** core/urxe_vote.sv ***
// Purpose: three-sample majority and noise vote
// Assumes: samples taken by the caller at the vote positions
// Notes:   purely combinational
`timescale 1ns/10ps
`default_nettype none
module urxe_vote (
    // the three samples
    input  wire logic [2:0] samples,
    // majority value and disagreement
    output logic            value,
    output logic            noisy
);
    // majority decides, any disagreement is noise
    always_comb begin
        value = (samples[0] & samples[1]) | (samples[0] & samples[2]) | (samples[1] & samples[2]);
        noisy = !(samples == 3'h0 || samples == 3'h7);
    end
endmodule
`default_nettype wire

// *** core/urxe_core.sv ***
// Purpose: serial receiver with status flags, errors, standby and wakeup
// Assumes: oversample_tick pulses one cycle at 16x baud; serial_in_line async
// Notes:   stop_mode freezes flags and buffer, returns state to idle, drops a character in flight
`timescale 1ns/10ps
`default_nettype none
`include "urxe_params.svh"
// Operation
// - stop not one sets frame error
// - break character sets frame error
// - frame error set with rx full
// - stop voted on samples eight to ten
// - tick phase resyncs on falling edges in idle and data
// - stop sampled tick ten after data
// - standby masks all receiver interrupts
// - address mark clears standby
// - waking address char sets rx full
// - idle wake sets neither quiet nor full
// - quiet count starts after start or stop
// - standby on idle line wakes again
// - full buffer sets rx full, irq gated
// - quiet after ten or eleven ones
// - overrun keeps old char, drops new
// - noise flag from any bit
// - frame irq gated by enable
// - parity mismatch sets parity fault
// - runs in wait, irq wakes
// - stop mode halts, drops char in flight
// - debug break protects flags from clears
// - tick runs at sixteen times baud
// - char length selects eight or nine bits
module urxe_core
    import urxe_pkg::*;
(
    // clock, reset, clock enable
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         clk_en,
    // link side
    input  wire logic         serial_in_line,
    input  wire logic         oversample_tick,
    // configuration
    input  wire logic         char_length_select,
    input  wire logic         parity_enable,
    input  wire logic         parity_odd,
    input  wire logic         standby_exit_select,
    input  wire logic         quiet_count_origin,
    input  wire logic         rx_enable,
    input  wire urxe_irq_en_t irq_en,
    // standby control from software
    input  wire logic         standby_set,
    // flag clears and buffer read from software
    input  wire urxe_flags_t  flag_clear,
    input  wire logic         data_read,
    // power and debug
    input  wire logic         wait_mode,
    input  wire logic         stop_mode,
    input  wire logic         debug_break,
    input  wire logic         break_clear_allow,
    // status outputs
    output urxe_flags_t       flags,
    output logic [8:0]        rx_data_buffer,
    output logic              rx_standby_bit,
    output logic              rx_irq,
    output logic              err_irq,
    output logic              wake_request
);
    logic [2:0]  sync_q;                 // pin synchroniser chain
    logic        line_q;                 // filtered line level
    logic        line_prev_q;            // level one tick ago
    urxe_state_t state_q;                // receiver state
    logic [3:0]  phase_q;                // tick phase within a bit
    logic [3:0]  bit_q;                  // data bits received
    logic [2:0]  smp_q;                  // vote samples
    logic [8:0]  shift_q;                // receive shift register
    logic        noise_acc_q;            // noise seen this character
    logic [3:0]  ones_q;                 // consecutive ones toward idle
    logic        quiet_armed_q;          // idle counting allowed
    logic        quiet_done_q;           // idle already reported
    urxe_flags_t flags_q;                // flag registers
    logic [8:0]  data_q;                 // receive buffer
    logic        standby_q;              // standby bit
    logic        run;                    // advance this cycle
    logic        tick;                   // run and oversample tick
    logic        vote_val;               // majority result
    logic        vote_noisy;             // sample disagreement
    logic [3:0]  data_bits;              // data bits per character plus one
    logic [3:0]  idle_len;               // ones for idle
    logic        stop_done;              // stop bit judged now
    logic        idle_hit;               // idle character detected
    logic        clr_ok;                 // clears permitted now
    logic        par_bad;                // parity mismatch
    logic        mark_bit;               // most significant data bit
    logic        fe_set;                 // frame error this char
    logic [2:0]  vote_in;                // samples fed to the voter
    logic        ne_set;                 // noise this char

    // stop mode halts all but the synchroniser and sends the receiver to idle, clock enable freezes
    assign run  = clk_en && !stop_mode;
    // tick runs at sixteen times baud, supplied from outside
    assign tick = run && oversample_tick;
    // length selects bits and idle length
    assign data_bits = char_length_select ? `URXE_BITS_9 : `URXE_BITS_8;
    assign idle_len  = char_length_select ? `URXE_IDLE_9 : `URXE_IDLE_8;
    // debug break blocks clears unless allowed
    assign clr_ok = !debug_break || break_clear_allow;

    // majority voter for start, data and stop bits
    // on the stop tick the third sample is the pin itself
    assign vote_in = stop_done ? {line_q, smp_q[1:0]} : smp_q;
    urxe_vote u_vote (
        .samples (vote_in),
        .value   (vote_val),
        .noisy   (vote_noisy)
    );

    // three-flop synchroniser, change taken when last two agree
    always_ff @(posedge clk) begin
        if (rst) begin
            sync_q <= 3'h7;
            line_q <= 1'b1;
        end else if (clk_en) begin
            sync_q <= {sync_q[1:0], serial_in_line};
            if (sync_q[1] == sync_q[2]) begin
                line_q <= sync_q[2];
            end
        end
    end

    // stop bit moment and character results
    assign stop_done = state_q == URXE_STOP && tick && phase_q == `URXE_BIT_S3;
    // both lengths hold the last data bit in the top position here
    assign mark_bit  = shift_q[8];
    assign par_bad   = parity_enable
                       && ((char_length_select ? ^shift_q[8:0] : ^shift_q[8:1]) != parity_odd);
    // stop not one sets frame error
    // break has no stop bit, same path
    // more than one bad sample means frame error
    assign fe_set = !vote_val;
    assign ne_set = noise_acc_q || vote_noisy;

    // receiver sequencing and sampling
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q     <= URXE_IDLE;
            phase_q     <= 4'h0;
            bit_q       <= 4'h0;
            smp_q       <= 3'h7;
            shift_q     <= `URXE_DATA_RESET;
            noise_acc_q <= 1'b0;
            line_prev_q <= 1'b1;
        end else if (clk_en && stop_mode) begin
            state_q <= URXE_IDLE;
        end else if (tick) begin
            line_prev_q <= line_q;
            phase_q     <= phase_q + 4'h1;
            if (phase_q == `URXE_START_S1 || phase_q == `URXE_BIT_S1) begin
                smp_q[0] <= line_q;
            end
            if (phase_q == `URXE_START_S2 || phase_q == `URXE_BIT_S2) begin
                smp_q[1] <= line_q;
            end
            if (phase_q == `URXE_START_S3 || phase_q == `URXE_BIT_S3) begin
                smp_q[2] <= line_q;
            end
            case (state_q)
                URXE_IDLE: begin
                    // phase runs free so idle bit times can be counted
                    if (rx_enable && line_prev_q && !line_q) begin
                        phase_q     <= 4'h1;
                        state_q     <= URXE_START;
                        noise_acc_q <= 1'b0;
                        bit_q       <= 4'h0;
                    end
                end
                URXE_START: begin
                    if (phase_q == `URXE_START_S3 + 4'h1) begin
                        if (vote_val) begin
                            state_q <= URXE_IDLE;
                        end else if (vote_noisy) begin
                            noise_acc_q <= 1'b1;
                        end
                    end
                    if (phase_q == `URXE_LAST_TICK) begin
                        state_q <= URXE_DATA;
                    end
                end
                URXE_DATA: begin
                    // resync phase on falling edge within char
                    if (line_prev_q && !line_q && phase_q > `URXE_BIT_S3) begin
                        phase_q <= 4'h1;
                    end
                    if (phase_q == `URXE_BIT_S3 + 4'h1) begin
                        shift_q     <= {vote_val, shift_q[8:1]};
                        noise_acc_q <= noise_acc_q | vote_noisy;
                        bit_q       <= bit_q + 4'h1;
                    end
                    if (phase_q == `URXE_LAST_TICK && bit_q == data_bits - 4'h1) begin
                        state_q <= URXE_STOP;
                    end
                end
                URXE_STOP: begin
                    // stop judged at tick ten of the stop bit
                    if (phase_q == `URXE_BIT_S3) begin
                        state_q <= URXE_IDLE;
                        if (!char_length_select) begin
                            shift_q <= {1'b0, shift_q[8:1]};
                        end
                    end
                end
                default: state_q <= URXE_IDLE;
            endcase
        end
    end

    // vote at stop uses sample three taken this same tick
    // so the voter sees the pin directly on the stop tick
    // idle counting of consecutive ones
    always_ff @(posedge clk) begin
        if (rst) begin
            ones_q        <= 4'h0;
            quiet_armed_q <= 1'b0;
            quiet_done_q  <= 1'b0;
        end else if (tick && phase_q == `URXE_LAST_TICK) begin
            // count origin after start or after stop
            if (state_q == URXE_START && !quiet_count_origin) begin
                quiet_armed_q <= 1'b1;
            end
            if (!line_q) begin
                ones_q       <= 4'h0;
                quiet_done_q <= 1'b0;
                quiet_armed_q <= !quiet_count_origin
                                 && (quiet_armed_q || state_q == URXE_START);
            end else if (quiet_armed_q && ones_q != idle_len) begin
                ones_q <= ones_q + 4'h1;
                if (idle_hit) begin
                    quiet_done_q <= 1'b1;
                end
            end
        end else if (stop_done && quiet_count_origin) begin
            quiet_armed_q <= 1'b1;
            ones_q        <= 4'h0;
        end
    end
    // idle after ten or eleven ones
    assign idle_hit = tick && phase_q == `URXE_LAST_TICK && line_q && quiet_armed_q
                      && ones_q == idle_len - 4'h1 && !quiet_done_q;

    // standby bit: software sets, wakeup clears
    always_ff @(posedge clk) begin
        if (rst) begin
            standby_q <= 1'b0;
        end else if (run) begin
            if (stop_done && standby_q && standby_exit_select && mark_bit) begin
                standby_q <= 1'b0;
            end else if (standby_q && !standby_exit_select
                         && (idle_hit || (line_q && quiet_done_q))) begin
                standby_q <= 1'b0;
            end else if (standby_set) begin
                // host sets standby again on mismatch
                standby_q <= 1'b1;
            end
        end
    end

    // status flags and receive buffer
    always_ff @(posedge clk) begin
        if (rst) begin
            flags_q <= '0;
            data_q  <= `URXE_DATA_RESET;
        end else if (run) begin
            if (clr_ok) begin
                flags_q <= flags_q & ~flag_clear;
                if (data_read) begin
                    flags_q.rx_full <= 1'b0;
                end
            end
            // idle wake does not raise quiet
            if (idle_hit && !(standby_q && !standby_exit_select)) begin
                flags_q.quiet <= 1'b1;
            end
            if (stop_done && !(standby_q && !(standby_exit_select && mark_bit))) begin
                if (flags_q.rx_full && !(clr_ok && data_read)) begin
                    flags_q.overrun <= 1'b1;
                end else begin
                    // character moves to buffer, full set
                    data_q          <= char_length_select ? shift_q
                                       : {1'b0, shift_q[8:1]};
                    flags_q.rx_full <= 1'b1;
                    // frame error set with rx full
                    flags_q.frame   <= fe_set;
                    // noise from start, data or stop
                    flags_q.noise   <= ne_set;
                    flags_q.par_fault <= par_bad;
                end
            end
        end
    end

    // outputs
    assign flags          = flags_q;
    assign rx_data_buffer = data_q;
    assign rx_standby_bit = standby_q;
    // frame irq gated by its enable
    assign rx_irq  = !standby_q && ((flags_q.rx_full && irq_en.rx_full)
                                    || (flags_q.quiet && irq_en.quiet));
    assign err_irq = !standby_q && |(flags_q[3:0] & irq_en[3:0]);
    // any enabled request ends wait mode
    assign wake_request = wait_mode && (rx_irq || err_irq);

    // frame error appears only with rx full
    frame_with_full_a: assert property (@(posedge clk) disable iff (rst)
        $rose(flags_q.frame) |-> $rose(flags_q.rx_full))
        else $error("frame error rose without rx full");
    standby_mask_a: assert property (@(posedge clk) disable iff (rst)
        standby_q |-> !rx_irq && !err_irq)
        else $error("interrupt during standby");
    overrun_keep_a: assert property (@(posedge clk) disable iff (rst)
        $rose(flags_q.overrun) |-> $stable(data_q))
        else $error("buffer changed on overrun");
    // flags not cleared in protected break
    break_protect_a: assert property (@(posedge clk) disable iff (rst)
        debug_break && !break_clear_allow && run && !stop_done && !idle_hit
        |=> flags_q == $past(flags_q))
        else $error("flag changed during protected break");
    stop_freeze_a: assert property (@(posedge clk) disable iff (rst)
        stop_mode |=> $stable(flags_q) && $stable(data_q))
        else $error("state moved in stop mode");
    // full set only on character completion
    full_cause_a: assert property (@(posedge clk) disable iff (rst)
        $rose(flags_q.rx_full) |-> $past(stop_done))
        else $error("rx full without character");
    frame_irq_a: assert property (@(posedge clk) disable iff (rst)
        flags_q.frame && irq_en.frame && !standby_q |-> err_irq)
        else $error("frame irq missing");
    wait_wake_a: assert property (@(posedge clk) disable iff (rst)
        wait_mode && rx_irq |-> wake_request)
        else $error("wait not ended");
endmodule
`default_nettype wire

// *** verif/urxe_tx_model.sv ***
// Purpose: remote asynchronous transmitter driving the receive line
// Assumes: one bit lasts sixteen oversample ticks, idle line is high
// Notes:   an optional one-tick glitch marks a chosen bit as noisy
`timescale 1ns/10ps
`default_nettype none
module urxe_tx_model (
    // clock and oversample tick
    input  wire logic        clk,
    input  wire logic        tick,
    // frame request, bits lsb first, start bit in bit 0
    input  wire logic        go,
    input  wire logic [10:0] frame,
    input  wire logic [3:0]  nbits,
    input  wire logic [3:0]  glitch,
    // line and status
    output logic             line,
    output logic             busy
);
    logic [10:0] sh_q  = 11'h7FF; // frame being sent
    logic [3:0]  nb_q  = 4'h0;    // bits in the frame
    logic [3:0]  gl_q  = 4'hF;    // bit index to glitch
    logic [3:0]  idx_q = 4'h0;    // current bit
    logic [3:0]  t_q   = 4'h0;    // tick within the bit
    logic        raw_q = 1'b1;    // line before glitch
    logic        busy_q = 1'b0;   // frame in progress
    always @(posedge clk) begin
        if (go && !busy_q) begin
            sh_q   <= frame;
            nb_q   <= nbits;
            gl_q   <= glitch;
            idx_q  <= 4'h0;
            t_q    <= 4'h0;
            busy_q <= 1'b1;
            raw_q  <= frame[0];
        end else if (busy_q && tick) begin
            t_q <= t_q + 4'h1;
            if (t_q == 4'hF) begin
                idx_q <= idx_q + 4'h1;
                // back to idle high after the last bit
                if (idx_q + 4'h1 == nb_q) begin
                    busy_q <= 1'b0;
                    raw_q  <= 1'b1;
                end else begin
                    raw_q <= sh_q[idx_q + 4'h1];
                end
            end
        end
    end
    // one-tick inversion disturbs a single vote sample only
    assign line = raw_q ^ (busy_q && idx_q == gl_q && t_q == 4'h8);
    assign busy = busy_q;
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// Purpose: self-checking bench for the receiver status and wakeup block
// Assumes: tick every fourth clock, so one bit is 64 clocks
// Notes:   driver queues expected characters, a monitor compares them
`timescale 1ns/10ps
`default_nettype none
`define URXE_CHK(nm, e, s) \
    begin \
        samples_checked++; \
        if ((s) !== (e)) begin \
            n_mismatch++; \
            $display("mismatch %s exp %0h seen %0h", nm, e, s); \
        end \
    end
module tb;
    import urxe_pkg::*;
    // expected result of one character
    typedef struct packed {
        logic [8:0] data;
        logic       frame;
        logic       noise;
        logic       par;
        logic       err;
    } urxe_exp_t;
    logic clk, rst, clk_en, serial_in_line, oversample_tick;
    logic char_length_select, parity_enable, parity_odd;
    logic standby_exit_select, quiet_count_origin, rx_enable;
    logic standby_set, data_read, wait_mode, stop_mode;
    logic debug_break, break_clear_allow, rx_standby_bit;
    logic rx_irq, err_irq, wake_request, go, busy, prev_full;
    urxe_irq_en_t irq_en;
    urxe_flags_t  flag_clear, flags;
    logic [8:0]   rx_data_buffer;
    logic [10:0]  frame;
    logic [3:0]   nbits, glitch;
    logic [1:0]   tick_cnt;
    urxe_exp_t    q[$];
    int           n_mismatch, samples_checked;
    urxe_core u_urxe_core (.clk(clk), .rst(rst), .clk_en(clk_en),
        .serial_in_line(serial_in_line), .oversample_tick(oversample_tick),
        .char_length_select(char_length_select), .parity_enable(parity_enable),
        .parity_odd(parity_odd), .standby_exit_select(standby_exit_select),
        .quiet_count_origin(quiet_count_origin), .rx_enable(rx_enable),
        .irq_en(irq_en), .standby_set(standby_set), .flag_clear(flag_clear),
        .data_read(data_read), .wait_mode(wait_mode), .stop_mode(stop_mode),
        .debug_break(debug_break), .break_clear_allow(break_clear_allow),
        .flags(flags), .rx_data_buffer(rx_data_buffer),
        .rx_standby_bit(rx_standby_bit), .rx_irq(rx_irq), .err_irq(err_irq),
        .wake_request(wake_request));
    urxe_tx_model u_urxe_tx_model (.clk(clk), .tick(oversample_tick), .go(go),
        .frame(frame), .nbits(nbits), .glitch(glitch), .line(serial_in_line),
        .busy(busy));
    // clock, 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // oversample tick, one clock in four
    always @(posedge clk) begin
        tick_cnt <= tick_cnt + 2'h1;
        oversample_tick <= (tick_cnt == 2'h3);
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // clear pulse and buffer read together
    task automatic clr(input urxe_flags_t m, input logic r);
        flag_clear <= m;
        data_read <= r;
        @(posedge clk);
        flag_clear <= '0;
        data_read <= 1'b0;
    endtask
    task automatic stby();
        standby_set <= 1'b1;
        @(posedge clk);
        standby_set <= 1'b0;
        cyc(2);
    endtask
    // one character: start, data lsb first, stop value
    task automatic send(input logic [8:0] d, input logic stp, input logic [3:0] gl);
        logic [10:0] f;
        int n;
        n = char_length_select ? 9 : 8;
        f = 11'h7FF;
        f[0] = 1'b0;
        for (int i = 0; i < n; i++) f[i + 1] = d[i];
        f[n + 1] = stp;
        frame <= f;
        nbits <= 4'(n + 2);
        glitch <= gl;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        cyc(2);
        for (int k = 0; k < 2000 && busy; k++) @(posedge clk);
        cyc(40);
    endtask
    function automatic urxe_exp_t mk(logic [8:0] d, logic f, logic n, logic p);
        mk = '{d, f, n, p, (f & irq_en.frame) | (n & irq_en.noise)
               | (p & irq_en.par_fault)};
    endfunction
    // monitor: each new full buffer takes the oldest note
    always @(posedge clk) begin
        urxe_exp_t e;
        prev_full <= flags.rx_full;
        if (flags.rx_full === 1'b1 && prev_full === 1'b0 && q.size() > 0) begin
            e = q.pop_front();
            `URXE_CHK("data", e.data, rx_data_buffer);
            `URXE_CHK("frame", e.frame, flags.frame);
            `URXE_CHK("noise", e.noise, flags.noise);
            `URXE_CHK("parity", e.par, flags.par_fault);
            `URXE_CHK("rx_irq", 1'b1, rx_irq);
            `URXE_CHK("err_irq", e.err, err_irq);
        end
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // watchdog, about three times the expected run
    initial begin
        cyc(60000);
        n_mismatch++;
        complete_run();
    end
    // main sequence
    initial begin
        logic [8:0] d;
        logic [6:0] d7;
        {clk_en, rx_enable, rst, prev_full} = 4'hE;
        {char_length_select, parity_enable, parity_odd} = 3'h0;
        {standby_exit_select, quiet_count_origin, standby_set} = 3'h0;
        {data_read, wait_mode, stop_mode, debug_break} = 4'h0;
        {break_clear_allow, go, tick_cnt, oversample_tick} = 5'h00;
        irq_en = '1;
        flag_clear = '0;
        frame = 11'h7FF;
        nbits = 4'h0;
        glitch = 4'hF;
        void'($urandom(32'h64B3));
        cyc(5);
        rst <= 1'b0;
        cyc(10);
        for (int m = 0; m < 2; m++) begin
            char_length_select <= m[0];
            cyc(2);
            repeat (3) begin
                d = 9'($urandom) & (m ? 9'h1FF : 9'h0FF);
                q.push_back(mk(d, 1'b0, 1'b0, 1'b0));
                send(d, 1'b1, 4'hF);
                clr('0, 1'b1);
            end
        end
        char_length_select <= 1'b0;
        // bad stop, masked frame irq, break
        for (int k = 0; k < 3; k++) begin
            irq_en.frame <= (k != 1);
            cyc(2);
            d = (k == 2) ? 9'h000 : 9'h0FF & 9'($urandom);
            q.push_back(mk(d, 1'b1, 1'b0, 1'b0));
            send(d, 1'b0, 4'hF);
            clr('0, 1'b1);
        end
        // noisy data bit, then noisy stop bit
        for (int k = 0; k < 2; k++) begin
            d = 9'h079 & 9'($urandom);
            q.push_back(mk(d, 1'b0, 1'b1, 1'b0));
            send(d, 1'b1, k ? 4'h9 : 4'h1);
            clr('0, 1'b1);
        end
        // parity even and odd, good and bad
        parity_enable <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            parity_odd <= k[1];
            d7 = 7'($urandom);
            d = {1'b0, (^d7) ^ k[1] ^ k[0], d7};
            q.push_back(mk(d, 1'b0, 1'b0, k[0]));
            send(d, 1'b1, 4'hF);
            clr('0, 1'b1);
        end
        parity_enable <= 1'b0;
        q.push_back(mk(9'h03C, 1'b0, 1'b0, 1'b0));
        send(9'h03C, 1'b1, 4'hF);
        send(9'h0C3, 1'b1, 4'hF);
        `URXE_CHK("overrun", 1'b1, flags.overrun);
        `URXE_CHK("kept", 9'h03C, rx_data_buffer);
        `URXE_CHK("or_irq", 1'b1, err_irq);
        clr(6'h08, 1'b1);
        wait_mode <= 1'b1;
        q.push_back(mk(9'h011, 1'b0, 1'b0, 1'b0));
        send(9'h011, 1'b1, 4'hF);
        `URXE_CHK("wake", 1'b1, wake_request);
        clr(6'h10, 1'b1);
        cyc(2);
        `URXE_CHK("wake_off", 1'b0, wake_request);
        wait_mode <= 1'b0;
        for (int o = 0; o < 2; o++) begin
            quiet_count_origin <= o[0];
            clr(6'h10, 1'b0);
            q.push_back(mk(9'h0FF, 1'b0, 1'b0, 1'b0));
            send(9'h0FF, 1'b1, 4'hF);
            clr('0, 1'b1);
            cyc(320);
            `URXE_CHK("quiet_early", o == 0, flags.quiet);
            cyc(448);
            `URXE_CHK("quiet", 1'b1, flags.quiet);
            `URXE_CHK("q_irq", 1'b1, rx_irq);
            clr(6'h10, 1'b0);
        end
        standby_exit_select <= 1'b1;
        stby();
        send(9'h055, 1'b1, 4'hF);
        `URXE_CHK("sb_irq", 2'h0, {rx_irq, err_irq});
        `URXE_CHK("sb_hold", 1'b1, rx_standby_bit);
        clr('1, 1'b1);
        q.push_back(mk(9'h0A5, 1'b0, 1'b0, 1'b0));
        send(9'h0A5, 1'b1, 4'hF);
        `URXE_CHK("sb_wake", 1'b0, rx_standby_bit);
        clr('0, 1'b1);
        stby();
        `URXE_CHK("sb_again", 1'b1, rx_standby_bit);
        standby_exit_select <= 1'b0;
        send(9'h066, 1'b1, 4'hF);
        cyc(768);
        `URXE_CHK("idle_wake", 3'h0, {rx_standby_bit, flags.quiet, flags.rx_full});
        stby();
        cyc(768);
        `URXE_CHK("idle_rewake", 1'b0, rx_standby_bit);
        // stop mode drops the character in flight
        fork
            send(9'h01E, 1'b1, 4'hF);
            begin
                cyc(300);
                stop_mode <= 1'b1;
            end
        join
        stop_mode <= 1'b0;
        cyc(768);
        `URXE_CHK("stop_full", 1'b0, flags.rx_full);
        `URXE_CHK("stop_buf", 9'h0A5, rx_data_buffer);
        q.push_back(mk(9'h042, 1'b1, 1'b0, 1'b0));
        send(9'h042, 1'b0, 4'hF);
        debug_break <= 1'b1;
        clr(6'h02, 1'b1);
        cyc(2);
        `URXE_CHK("brk_keep", 2'h3, {flags.rx_full, flags.frame});
        break_clear_allow <= 1'b1;
        clr(6'h02, 1'b1);
        cyc(2);
        `URXE_CHK("brk_clear", 2'h0, {flags.rx_full, flags.frame});
        debug_break <= 1'b0;
        cyc(10);
        complete_run();
    end
endmodule
`default_nettype wire
